// ### design/gdu_protect_ctrl.sv
// Register file, protection flags, interrupts and boost clock of the gate drive unit.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gdu_protect_ctrl
	import gdu_ctrl_pkg::*;
(
	// Clock and reset.
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RST,
	// Register port.
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	// CPU mode.
	input  wire logic        I_RUN_MODE,
	// Analog comparator levels.
	input  wire logic [2:0]  I_HS_DESAT,
	input  wire logic [2:0]  I_LS_DESAT,
	input  wire logic        I_LOW_VOLT,
	input  wire logic        I_HIGH_VOLT,
	input  wire logic [1:0]  I_OC_COMP,
	input  wire logic        I_VSUP_LOW,
	// Overcurrent and sense amplifier controls.
	output logic      [5:0]  O_OC_DAC_CODE0,
	output logic      [5:0]  O_OC_DAC_CODE1,
	output logic      [1:0]  O_OC_COMP_ON,
	output logic      [1:0]  O_SENSE_AMP_ON,
	output logic      [1:0]  O_OC_ACTION,
	output logic      [2:0]  O_SENSE_OFFSET,
	// Link monitor and boost converter.
	output logic             O_DC_LINK_ADC_EN,
	output logic             O_BOOST_CLK,
	output logic      [3:0]  O_BOOST_LIMIT,
	// Pre-driver controls.
	output logic      [2:0]  O_SLEW_CODE,
	output logic      [6:0]  O_IREF_UA,
	output logic      [2:0]  O_HS_BLOCK,
	output logic      [2:0]  O_LS_BLOCK,
	// Interrupt lines.
	output logic             O_DESAT_IRQ,
	output logic             O_FAULT_IRQ
);
	logic [7:0]        ctrl_reg;
	logic [7:0]        thresh_reg;
	logic [2:0]        offset_reg;
	logic [3:0]        blimit_reg;
	logic [2:0]        bdiv_reg;
	logic [2:0]        slew_reg;
	logic [IEN_W-1:0]  irq_en_reg;
	logic [FLG_W-1:0]  flags_reg;
	logic [FLG_W-1:0]  flags_next;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	logic [5:0]        dac0_reg;
	logic [5:0]        dac1_reg;
	logic [1:0]        comp_on_reg;
	logic [6:0]        iref_reg;
	logic [2:0]        hs_block_reg;
	logic [2:0]        ls_block_reg;
	logic              desat_irq_reg;
	logic              fault_irq_reg;
	logic [7:0]        div_cnt_reg;
	logic              boost_clk_reg;

	pin_sense_if #(.W(PIN_W)) pins ();

	pin_filter #(.W(PIN_W)) u_filter (
		.i_clk (I_SYS_CLK),
		.i_rst (I_RST),
		.p     (pins.filt)
	);

	assign pins.raw = {I_VSUP_LOW, I_OC_COMP, I_HIGH_VOLT,
		I_LOW_VOLT, I_LS_DESAT, I_HS_DESAT};

	wire [2:0] hs_level = pins.clean[2:0];
	wire [2:0] ls_level = pins.clean[5:3];
	wire       lv_level = pins.clean[6];
	wire       hv_level = pins.clean[7];
	wire [1:0] oc_level = pins.clean[9:8];
	wire       vsup_low = pins.clean[10];

	// Address decode.
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	wire wr_ctrl   = I_WR && hit(I_ADDR, ADDR_CTRL);
	wire wr_thresh = I_WR && hit(I_ADDR, ADDR_THRESH);
	wire wr_offset = I_WR && hit(I_ADDR, ADDR_OFFSET);
	wire wr_blimit = I_WR && hit(I_ADDR, ADDR_BLIMIT);
	wire wr_bdiv   = I_WR && hit(I_ADDR, ADDR_BDIV);
	wire wr_slew   = I_WR && hit(I_ADDR, ADDR_SLEW);
	wire wr_irq_en = I_WR && hit(I_ADDR, ADDR_IRQ_EN);
	wire wr_flags  = I_WR && hit(I_ADDR, ADDR_FLAGS);

	wire [1:0] oc_en   = ctrl_reg[CTRL_OC_EN +: 2];
	wire [1:0] amp_en  = ctrl_reg[CTRL_AMP_EN +: 2];
	wire [3:0] thr0    = thresh_reg[3:0];
	wire [3:0] thr1    = thresh_reg[THR1_POS +: 4];

	// A comparator is live only with both of its enables set.
	wire [1:0] oc_live = oc_en & amp_en;

	// Flag events: desat, supply and live overcurrent levels.
	wire [FLG_W-1:0] flag_set = {oc_level & oc_live,
		hv_level, lv_level, ls_level, hs_level};
	wire [FLG_W-1:0] flag_clr = wr_flags ? I_WDATA[FLG_W-1:0]
		: '0;

	// Set wins over a write-one clear in the same cycle. Nothing
	// else touches the flags, so stop mode entry and exit leave them.
	assign flags_next = (flags_reg & ~flag_clr) | flag_set;

	wire [2:0] hs_flag = flags_reg[FLG_HS +: 3];
	wire [2:0] ls_flag = flags_reg[FLG_LS +: 3];
	wire [1:0] oc_flag = flags_reg[FLG_OC +: 2];

	wire desat_any = (|hs_flag) | (|ls_flag);
	wire desat_req = desat_any && irq_en_reg[IEN_DESAT];
	wire fault_req =
		(flags_reg[FLG_LV] && irq_en_reg[IEN_LV]) ||
		(flags_reg[FLG_HV] && irq_en_reg[IEN_HV]) ||
		(|(oc_flag & irq_en_reg[IEN_OC +: 2]));

	// Boost divider: half period of 2^sel bus cycles.
	function automatic logic [7:0] half_period(input logic [2:0] s);
		half_period = 8'h01 << s;
	endfunction : half_period

	wire       div_tick  = (div_cnt_reg == half_period(bdiv_reg)
		- 8'h01);
	wire       boost_run = ctrl_reg[CTRL_BOOST] && vsup_low;

	wire [6:0] iref_next = IREF_BASE_UA
		+ IREF_STEP_UA * {4'h0, slew_reg};

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (I_ADDR)
			ADDR_CTRL:   rdata_next[7:0] = ctrl_reg;
			ADDR_THRESH: rdata_next[7:0] = thresh_reg;
			ADDR_OFFSET: rdata_next[2:0] = offset_reg;
			ADDR_BLIMIT: rdata_next[3:0] = blimit_reg;
			ADDR_BDIV:   rdata_next[2:0] = bdiv_reg;
			ADDR_SLEW:   rdata_next[2:0] = slew_reg;
			ADDR_IRQ_EN: rdata_next[IEN_W-1:0] = irq_en_reg;
			ADDR_FLAGS:  rdata_next[FLG_W-1:0] = flags_reg;
			ADDR_STATUS: rdata_next[PIN_W:0] =
				{boost_clk_reg, pins.clean};
			default:     rdata_next = 32'h0000_0000;
		endcase
	end

	// Configuration registers.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			ctrl_reg   <= CTRL_RST;
			thresh_reg <= THRESH_RST;
			offset_reg <= OFFSET_RST;
			blimit_reg <= BLIMIT_RST;
			bdiv_reg   <= BDIV_RST;
			slew_reg   <= SLEW_RST;
			irq_en_reg <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= I_WDATA[7:0];
			if (wr_thresh)
				thresh_reg <= I_WDATA[7:0];
			if (wr_offset)
				offset_reg <= I_WDATA[2:0];
			if (wr_blimit)
				blimit_reg <= I_WDATA[3:0];
			if (wr_bdiv)
				bdiv_reg <= I_WDATA[2:0];
			if (wr_slew)
				slew_reg <= I_WDATA[2:0];
			if (wr_irq_en)
				irq_en_reg <= I_WDATA[IEN_W-1:0];
		end
	end

	// Read data stands for one cycle only.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= I_RD ? rdata_next : 32'h0000_0000;
	end

	// Flags and interrupt lines; requests are held off outside run mode.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			flags_reg     <= '0;
			desat_irq_reg <= 1'b0;
			fault_irq_reg <= 1'b0;
		end else begin
			flags_reg     <= flags_next;
			desat_irq_reg <= I_RUN_MODE && desat_req;
			fault_irq_reg <= I_RUN_MODE && fault_req;
		end
	end

	// Derived analog controls, registered so every output is a flop.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			dac0_reg     <= '0;
			dac1_reg     <= '0;
			comp_on_reg  <= '0;
			iref_reg     <= '0;
			hs_block_reg <= '0;
			ls_block_reg <= '0;
		end else begin
			dac0_reg     <= {DAC_TOP, thr0};
			dac1_reg     <= {DAC_TOP, thr1};
			comp_on_reg  <= oc_live;
			iref_reg     <= iref_next;
			hs_block_reg <= hs_flag;
			ls_block_reg <= ls_flag;
		end
	end

	// The divider free-runs; the enable gate only stops the output,
	// which parks low so the switch transistor is left off.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			div_cnt_reg   <= 8'h00;
			boost_clk_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
			if (!boost_run)
				boost_clk_reg <= 1'b0;
			else if (div_tick)
				boost_clk_reg <= ~boost_clk_reg;
		end
	end

	assign O_RDATA          = rdata_reg;
	assign O_OC_DAC_CODE0   = dac0_reg;
	assign O_OC_DAC_CODE1   = dac1_reg;
	assign O_OC_COMP_ON     = comp_on_reg;
	assign O_SENSE_AMP_ON   = amp_en;
	assign O_OC_ACTION      = ctrl_reg[CTRL_ACT +: 2];
	assign O_SENSE_OFFSET   = offset_reg;
	assign O_DC_LINK_ADC_EN = ctrl_reg[CTRL_DCL];
	assign O_BOOST_CLK      = boost_clk_reg;
	assign O_BOOST_LIMIT    = blimit_reg;
	assign O_SLEW_CODE      = slew_reg;
	assign O_IREF_UA        = iref_reg;
	assign O_HS_BLOCK       = hs_block_reg;
	assign O_LS_BLOCK       = ls_block_reg;
	assign O_DESAT_IRQ      = desat_irq_reg;
	assign O_FAULT_IRQ      = fault_irq_reg;

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);

	dac_code_a: assert property (
		!I_RST |=> O_OC_DAC_CODE0 == {2'b11, $past(thr0)}
			&& O_OC_DAC_CODE1 == {2'b11, $past(thr1)})
		else $error("overcurrent reference code wrong");

	comp_gate_a: assert property (
		$rose(oc_flag[0]) |-> $past(oc_en[0] && amp_en[0]))
		else $error("overcurrent flag set while comparator off");

	irq_run_a: assert property (
		(O_FAULT_IRQ || O_DESAT_IRQ) |-> $past(I_RUN_MODE))
		else $error("interrupt raised outside run mode");

	flags_hold_a: assert property (
		(!wr_flags && flag_set == '0) |=> $stable(flags_reg))
		else $error("flags changed without cause");

	desat_irq_a: assert property (
		(I_RUN_MODE && desat_any && irq_en_reg[IEN_DESAT])
		|=> O_DESAT_IRQ)
		else $error("desaturation interrupt missing");

	fault_irq_a: assert property (
		(I_RUN_MODE && flags_reg[FLG_HV] && irq_en_reg[IEN_HV])
		|=> O_FAULT_IRQ)
		else $error("high voltage interrupt missing");

	boost_off_a: assert property (
		!boost_run [*2] |=> !O_BOOST_CLK)
		else $error("boost clock runs while disabled");

	iref_value_a: assert property (
		!I_RST |=> O_IREF_UA ==
			7'd10 + 7'd10 * {4'h0, $past(slew_reg)})
		else $error("reference current code wrong");

	desat_clear_a: assert property (
		(wr_flags && I_WDATA[FLG_HS] && !flag_set[FLG_HS])
		|=> !hs_flag[0] ##1 !O_HS_BLOCK[0])
		else $error("pre-driver still blocked after clear");

	irq_drop_a: assert property (
		(!desat_req && !fault_req) |=> !O_DESAT_IRQ && !O_FAULT_IRQ)
		else $error("interrupt line held without cause");

	oc1_gate_a: assert property (
		$rose(oc_flag[1]) |-> $past(oc_en[1] && amp_en[1]))
		else $error("overcurrent flag 1 set while comparator off");

	run_only_a: assert property (
		!I_RUN_MODE |=> !O_DESAT_IRQ && !O_FAULT_IRQ)
		else $error("interrupt line high after leaving run mode");

	oc_irq_a: assert property (
		(I_RUN_MODE && oc_flag[0] && irq_en_reg[IEN_OC])
		|=> O_FAULT_IRQ)
		else $error("overcurrent interrupt missing");

	lv_irq_a: assert property (
		(I_RUN_MODE && flags_reg[FLG_LV] && irq_en_reg[IEN_LV])
		|=> O_FAULT_IRQ)
		else $error("low voltage interrupt missing");

	boost_gate_a: assert property (
		$rose(O_BOOST_CLK) |-> $past(boost_run))
		else $error("boost clock rose while disabled");

	boost_step_a: assert property (
		($changed(O_BOOST_CLK) && $past(boost_run))
		|-> $past(div_tick))
		else $error("boost clock toggled off the divider tick");

	block_track_a: assert property (
		!I_RST |=> {O_LS_BLOCK, O_HS_BLOCK} ==
			$past({ls_flag, hs_flag}))
		else $error("pre-driver block does not follow its flag");

	offset_wr_a: assert property (
		wr_offset |=> O_SENSE_OFFSET == $past(I_WDATA[2:0]))
		else $error("offset trim not taken");

	limit_wr_a: assert property (
		wr_blimit |=> O_BOOST_LIMIT == $past(I_WDATA[3:0]))
		else $error("boost current limit not taken");

	link_en_a: assert property (
		wr_ctrl |=> O_DC_LINK_ADC_EN == $past(I_WDATA[CTRL_DCL]))
		else $error("link monitor enable not taken");
endmodule : gdu_protect_ctrl
`default_nettype wire

// ### design/gdu_ctrl_pkg.sv
// Constants shared by the gate drive protection and boost control block.
package gdu_ctrl_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;
	localparam logic [7:0] ADDR_BLIMIT = 8'h0c;
	localparam logic [7:0] ADDR_BDIV   = 8'h10;
	localparam logic [7:0] ADDR_SLEW   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
	localparam logic [7:0] ADDR_FLAGS  = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam int CTRL_OC_EN  = 0;
	localparam int CTRL_AMP_EN = 2;
	localparam int CTRL_ACT    = 4;
	localparam int CTRL_DCL    = 6;
	localparam int CTRL_BOOST  = 7;
	localparam int THR1_POS    = 4;
	localparam int FLG_HS = 0;
	localparam int FLG_LS = 3;
	localparam int FLG_LV = 6;
	localparam int FLG_HV = 7;
	localparam int FLG_OC = 8;
	localparam int FLG_W  = 10;
	localparam int IEN_DESAT = 0;
	localparam int IEN_LV    = 1;
	localparam int IEN_HV    = 2;
	localparam int IEN_OC    = 3;
	localparam int IEN_W     = 5;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] THRESH_RST = 8'h00;
	localparam logic [2:0] OFFSET_RST = 3'h0;
	localparam logic [3:0] BLIMIT_RST = 4'h0;
	localparam logic [2:0] BDIV_RST   = 3'h0;
	localparam logic [2:0] SLEW_RST   = 3'h0;
	localparam logic [1:0] DAC_TOP    = 2'h3;
	localparam logic [6:0] IREF_BASE_UA = 7'h0a;
	localparam logic [6:0] IREF_STEP_UA = 7'h0a;
	localparam int DC_LINK_DIVIDE = 5;
	localparam int PIN_W = 11;
endpackage : gdu_ctrl_pkg

// ### design/pin_sense_if.sv
// Interface carrying raw comparator levels and their filtered copies.
`timescale 1ns/1ps
`default_nettype none
interface pin_sense_if #(parameter int W = 11);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface : pin_sense_if
`default_nettype wire

// ### design/pin_filter.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
	parameter int W = 11
) (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Levels in and out.
	pin_sense_if.filt p
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] clean_reg;
	logic [W-1:0] agree;

	// Stage one feeds stage two only, so metastability never leaks out.
	assign agree   = ~(s2_reg ^ s3_reg);
	assign p.clean = clean_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			clean_reg <= '0;
		end else begin
			s1_reg    <= p.raw;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			clean_reg <= (agree & s3_reg) | (~agree & clean_reg);
		end
	end
endmodule : pin_filter
`default_nettype wire

// ### verif/bridge_model.sv
// Behavioural power bridge, sense resistor and comparators outside the block.
`timescale 1ns/1ps
`default_nettype none
module bridge_model (
	// Test controls.
	input  wire logic [5:0] i_current,
	input  wire logic [2:0] i_hs_short,
	input  wire logic [2:0] i_ls_short,
	// Block controls.
	input  wire logic [5:0] i_code0,
	input  wire logic [5:0] i_code1,
	input  wire logic [1:0] i_comp_on,
	input  wire logic [2:0] i_hs_block,
	input  wire logic [2:0] i_ls_block,
	// Comparator levels.
	output logic      [2:0] o_hs_desat,
	output logic      [2:0] o_ls_desat,
	output logic      [1:0] o_oc
);
	// A blocked pre-driver turns its FET off, which ends the desaturation.
	assign o_hs_desat = i_hs_short & ~i_hs_block;
	assign o_ls_desat = i_ls_short & ~i_ls_block;
	// An unpowered comparator holds its output low whatever the current.
	assign o_oc[0] = i_comp_on[0] && (i_current > i_code0);
	assign o_oc[1] = i_comp_on[1] && (i_current > i_code1);
endmodule : bridge_model
`default_nettype wire

// ### verif/gdu_protect_ctrl_test.sv
// Self-checking bench for the gate drive protection and boost control block.
`timescale 1ns/1ps
`default_nettype none
module gdu_protect_ctrl_test import gdu_ctrl_pkg::*;;
	logic        clk, rst, wr_en, rd_en, run, lv, hv, vlow;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [5:0]  cur, code0, code1;
	logic [2:0]  hs_sh, ls_sh, hs_d, ls_d, hs_blk, ls_blk, offs, slew;
	logic [1:0]  oc, comp_on, amp_on, act;
	logic [3:0]  blim;
	logic [6:0]  iref;
	logic        dcl, bclk, dirq, firq;
	int          error_cnt = 0;
	int          comparisons = 0;

	gdu_protect_ctrl i_gdu_protect_ctrl (.I_SYS_CLK(clk), .I_RST(rst),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en), .I_RD(rd_en),
		.O_RDATA(rdata), .I_RUN_MODE(run), .I_HS_DESAT(hs_d),
		.I_LS_DESAT(ls_d), .I_LOW_VOLT(lv), .I_HIGH_VOLT(hv),
		.I_OC_COMP(oc), .I_VSUP_LOW(vlow), .O_OC_DAC_CODE0(code0),
		.O_OC_DAC_CODE1(code1), .O_OC_COMP_ON(comp_on),
		.O_SENSE_AMP_ON(amp_on), .O_OC_ACTION(act), .O_SENSE_OFFSET(offs),
		.O_DC_LINK_ADC_EN(dcl), .O_BOOST_CLK(bclk), .O_BOOST_LIMIT(blim),
		.O_SLEW_CODE(slew), .O_IREF_UA(iref), .O_HS_BLOCK(hs_blk),
		.O_LS_BLOCK(ls_blk), .O_DESAT_IRQ(dirq), .O_FAULT_IRQ(firq));

	bridge_model i_bridge_model (.i_current(cur), .i_hs_short(hs_sh),
		.i_ls_short(ls_sh), .i_code0(code0), .i_code1(code1),
		.i_comp_on(comp_on), .i_hs_block(hs_blk), .i_ls_block(ls_blk),
		.o_hs_desat(hs_d), .o_ls_desat(ls_d), .o_oc(oc));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rdc

	task automatic results;
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic t_reset;
		step(2);
		chk(code0, 6'h30);
		chk(code1, 6'h30);
		chk({dirq, firq, bclk, dcl}, 4'h0);
		rdc(ADDR_CTRL, 32'h0);
		rdc(ADDR_FLAGS, 32'h0);
		rdc(8'hfc, 32'h0);
	endtask : t_reset

	task automatic t_regs;
		reg_wr(ADDR_THRESH, 32'h5a);
		step(2);
		chk(code0, 6'h3a);
		chk(code1, 6'h35);
		for (int c = 0; c < 8; c++) begin
			reg_wr(ADDR_SLEW, 32'(c));
			reg_wr(ADDR_OFFSET, 32'(7 - c));
			reg_wr(ADDR_BLIMIT, 32'(2 * c + 1));
			step(2);
			chk(slew, 32'(c));
			chk(iref, 32'(10 + 10 * c));
			chk(offs, 32'(7 - c));
			chk(blim, 32'(2 * c + 1));
		end
		rdc(ADDR_BLIMIT, 32'hf);
		// Both action bits are kept equal, as software must.
		reg_wr(ADDR_CTRL, 32'h70);
		step(1);
		chk(dcl, 1'b1);
		chk(act, 2'h3);
		reg_wr(ADDR_CTRL, 32'h0);
		step(1);
		chk(dcl, 1'b0);
	endtask : t_regs

	task automatic t_overcurrent;
		for (int e = 0; e < 16; e++) begin
			reg_wr(ADDR_CTRL, 32'(e));
			step(2);
			chk(comp_on, 32'(e & (e >> 2) & 3));
			chk(amp_on, 32'((e >> 2) & 3));
		end
		reg_wr(ADDR_THRESH, 32'h0);
		reg_wr(ADDR_IRQ_EN, 32'h18);
		reg_wr(ADDR_CTRL, 32'h07);
		cur <= 6'h3f;
		step(8);
		rdc(ADDR_FLAGS, 32'h100);
		chk(firq, 1'b1);
		cur <= 6'h00;
		step(6);
		reg_wr(ADDR_FLAGS, 32'h100);
		step(2);
		chk(firq, 1'b0);
	endtask : t_overcurrent

	task automatic t_voltage;
		reg_wr(ADDR_IRQ_EN, 32'h02);
		lv <= 1'b1;
		hv <= 1'b1;
		step(8);
		rdc(ADDR_STATUS, 32'hc0);
		rdc(ADDR_FLAGS, 32'hc0);
		chk(firq, 1'b1);
		lv <= 1'b0;
		step(6);
		reg_wr(ADDR_FLAGS, 32'h40);
		step(2);
		chk(firq, 1'b0);
		reg_wr(ADDR_IRQ_EN, 32'h04);
		step(2);
		chk(firq, 1'b1);
		reg_wr(ADDR_IRQ_EN, 32'h0);
		step(2);
		chk(firq, 1'b0);
		hv <= 1'b0;
		step(6);
		reg_wr(ADDR_FLAGS, 32'hc0);
	endtask : t_voltage

	task automatic t_desat;
		reg_wr(ADDR_IRQ_EN, 32'h01);
		hs_sh <= 3'b011;
		step(10);
		rdc(ADDR_FLAGS, 32'h3);
		chk(dirq, 1'b1);
		chk(hs_blk, 3'b011);
		run <= 1'b0;
		step(2);
		chk(dirq, 1'b0);
		rdc(ADDR_FLAGS, 32'h3);
		run <= 1'b1;
		step(2);
		chk(dirq, 1'b1);
		hs_sh <= 3'b000;
		reg_wr(ADDR_FLAGS, 32'h3);
		step(2);
		chk(dirq, 1'b0);
		chk(hs_blk, 3'b000);
		ls_sh <= 3'b100;
		step(10);
		chk(dirq, 1'b1);
		chk(ls_blk, 3'b100);
		reg_wr(ADDR_IRQ_EN, 32'h0);
		step(2);
		chk(dirq, 1'b0);
		ls_sh <= 3'b000;
		reg_wr(ADDR_FLAGS, 32'h20);
		step(2);
		chk(ls_blk, 3'b000);
	endtask : t_desat

	// Counts boost clock toggles over a window of 64 cycles.
	task automatic toggles(output int n);
		logic last;
		n = 0;
		last = bclk;
		repeat (64) begin
			step(1);
			n += int'(bclk !== last);
			last = bclk;
		end
	endtask : toggles

	task automatic t_boost;
		int n;
		reg_wr(ADDR_CTRL, 32'h80);
		toggles(n);
		chk(32'(n), 32'h0);
		vlow <= 1'b1;
		step(6);
		for (int s = 0; s < 3; s++) begin
			reg_wr(ADDR_BDIV, 32'(s));
			step(20);
			toggles(n);
			chk(32'(n), 32'(64 >> s));
		end
		reg_wr(ADDR_CTRL, 32'h0);
		step(2);
		toggles(n);
		chk({31'h0, bclk}, 32'h0);
		chk(32'(n), 32'h0);
	endtask : t_boost

	initial begin
		rst = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		run = 1'b1;
		lv = 1'b0;
		hv = 1'b0;
		vlow = 1'b0;
		cur = 6'h00;
		hs_sh = 3'h0;
		ls_sh = 3'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_overcurrent();
		t_voltage();
		t_desat();
		t_boost();
		results();
	end
endmodule : gdu_protect_ctrl_test
`default_nettype wire
